//--- src/reader_regs_cfg.svh
// Constants of the reader FIFO and test register group.
// Assumes inclusion by the package and reader_fifo_regs by bare name.
`ifndef READER_REGS_CFG_SVH
`define READER_REGS_CFG_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFS_TEST_PATH 5'h1A
`define OFS_TEST_MODE 5'h1B
`define OFS_FIFO_STATUS 5'h1C
`define OFS_TX_COUNT_HIGH 5'h1D
`define OFS_TX_COUNT_LOW 5'h1E
`define OFS_FIFO_DATA 5'h1F

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_TEST_PATH 8'h00
`define RST_TEST_MODE 8'h00
`define RST_TX_COUNT 8'h00

// ----------------------------------------
// test_path_control fields
// ----------------------------------------
`define BIT_SUBC_IN 7
`define BIT_SUBC_OUT 6
`define BIT_DIRECT_MOD 5
`define BIT_STAGE_SEL 4
`define BIT_STAGE2_LOW 3
`define BIT_STAGE1_LOW 2
`define BIT_FOLLOWER_TEST 1
`define BIT_AGC_TEST 0

// ----------------------------------------
// test_mode_control fields
// ----------------------------------------
`define BIT_RF_AMP_TEST 7
`define BIT_IO_TEST1 3
`define BIT_IO_TEST0 2
`define BIT_DEC_TEST 1
`define BIT_FAST_CLOCK 0

// ----------------------------------------
// fifo_level_status fields
// ----------------------------------------
`define BIT_FIFO_RESERVED 7
`define BIT_FIFO_HIGH 6
`define BIT_FIFO_LOW 5
`define BIT_FIFO_OVERFLOW 4
`define FIFO_COUNT_MSB 3

// ----------------------------------------
// tx_byte_count_low fields
// ----------------------------------------
`define BIT_PARTIAL_FLAG 0
`define PARTIAL_BITS_MSB 3
`define PARTIAL_BITS_LSB 1

// ----------------------------------------
// FIFO sizing and levels
// ----------------------------------------
`define FIFO_DEPTH 12
`define FIFO_HIGH_LEVEL 9
`define FIFO_LOW_LEVEL 3

`endif

//--- src/reader_regs_pkg.sv
// Types shared by the reader FIFO and test register group.
// Assumes the configuration header sits beside it.
`include "reader_regs_cfg.svh"

package reader_regs_pkg;
   // FIFO direction, Gray coded along idle, transmit, receive
   typedef enum logic [1:0] {
      DIR_IDLE = 2'b00,
      DIR_TX = 2'b01,
      DIR_RX = 2'b11
   } fifo_dir_type;
endpackage

//--- src/fifo_store.sv
// Byte store of the reader FIFO, one write and one read port.
// Assumes the owner keeps pointers in range; read data is registered.
`timescale 1ns/1ps
`default_nettype none

module fifo_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 12,
   parameter int AW = 4
) (
   // Clock
   input wire logic sys_clk,
   // Write port
   input wire logic wrEn,
   input wire logic [AW-1:0] wrAddr,
   input wire logic [WIDTH-1:0] wrData,
   // Read port
   input wire logic rdEn,
   input wire logic [AW-1:0] rdAddr,
   output logic [WIDTH-1:0] rdData
);
   logic [WIDTH-1:0] mem [DEPTH];

   // Storage needs no reset; the pointers decide what is valid
   always_ff @(posedge sys_clk) begin
      if (wrEn) begin
         mem[wrAddr] <= wrData;
      end
   end

   // Registered read
   always_ff @(posedge sys_clk) begin
      if (rdEn) begin
         rdData <= mem[rdAddr];
      end
   end
endmodule

`default_nettype wire

//--- src/reader_fifo_regs.sv
// FIFO control and test registers of the reader front-end.
// Assumes a synchronous host register port and sys_clk at 100 MHz.
`timescale 1ns/1ps
`default_nettype none
`include "reader_regs_cfg.svh"

module reader_fifo_regs
   import reader_regs_pkg::*;
#(
   parameter int DEPTH = `FIFO_DEPTH,
   parameter int HIGH_LEVEL = `FIFO_HIGH_LEVEL,
   parameter int LOW_LEVEL = `FIFO_LOW_LEVEL
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic chipEn,
   // Host register port
   input wire logic [4:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   output logic [7:0] regRdData,
   output logic regRdValid,
   input wire logic hostStop,
   // Protocol engine status
   input wire logic txActive,
   input wire logic rxActive,
   input wire logic txEof,
   input wire logic fifoClear,
   // Received bytes into the FIFO
   input wire logic rxByteValid,
   input wire logic [7:0] rxByte,
   output logic rxByteReady,
   // Transmit bytes toward the coder
   output logic txDataValid,
   output logic [7:0] txData,
   input wire logic txDataReady,
   // Transmit length to the coder
   output logic [11:0] txByteCount,
   output logic partialByte,
   output logic [2:0] partialBits,
   // Pins
   input wire logic keyingPinIn,
   input wire logic modulationPinIn,
   output logic modulationPinOut,
   output logic modulationPinOe,
   // Analog and decoder steering
   input wire logic internalSubcarrier,
   input wire logic rxSubcarrier,
   input wire logic coderModulation,
   input wire logic [2:0] rssiMainLevel,
   input wire logic [2:0] agcLevel,
   output logic decoderSubcarrier,
   output logic txModulation,
   output logic rxResetReq,
   output logic stageSelect,
   output logic stage1GainReduce,
   output logic stage2GainReduce,
   output logic followerTest,
   output logic rfAmplitudeTest,
   output logic [2:0] rssiMainShown,
   output logic testModeActive,
   output logic coderFastClock,
   output logic fifoEvent
);
   localparam int AW = 4;
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW:0] HIGH_C = (AW+1)'(HIGH_LEVEL);
   localparam logic [AW:0] LOW_C = (AW+1)'(LOW_LEVEL);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   // ----------------------------------------
   // Decoding and pointer helpers
   // ----------------------------------------
   function automatic logic hits(input logic [4:0] addr, input logic [4:0] ofs);
      hits = (addr == ofs);
   endfunction

   function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
      bump = (ptr == LAST_C) ? 4'h0 : ptr + 4'h1;
   endfunction

   logic [7:0] testPath_r;
   logic [7:0] testMode_r;
   logic [7:0] countHigh_r;
   logic [7:0] countLow_r;
   logic overflow_r;
   logic [AW-1:0] wrPtr_r;
   logic [AW-1:0] rdPtr_r;
   logic [AW:0] level_r;
   logic [AW:0] levelNxt;
   fifo_dir_type dir_r;
   fifo_dir_type dirNxt;
   logic hostWrFifo;
   logic hostRdFifo;
   logic pushEn;
   logic popEn;
   logic fillPop;
   logic [7:0] pushData;
   logic [7:0] memRdData;
   logic fillPending_r;
   logic hostRdFifo_r;
   logic [7:0] regRd_r;
   logic regRdValid_r;
   logic [7:0] statusView;
   logic [7:0] bufData_r [2];
   logic [1:0] bufValid_r;
   logic bufHead_r;
   logic [1:0] bufUsed;
   logic bufTake;

   // ----------------------------------------
   // FIFO direction state
   // ----------------------------------------
   always_comb begin
      dirNxt = dir_r;
      case (dir_r)
         DIR_IDLE: begin
            if (txActive) begin
               dirNxt = DIR_TX;
            end else if (rxActive) begin
               dirNxt = DIR_RX;
            end
         end
         DIR_TX: begin
            if (!txActive) begin
               dirNxt = rxActive ? DIR_RX : DIR_IDLE;
            end
         end
         DIR_RX: begin
            if (!rxActive) begin
               dirNxt = DIR_IDLE;
            end
         end
         default: dirNxt = DIR_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         dir_r <= DIR_IDLE;
      end else if (!chipEn) begin
         dir_r <= DIR_IDLE;
      end else begin
         dir_r <= dirNxt;
      end
   end

   // ----------------------------------------
   // Test registers
   // ----------------------------------------
   // Path control: plain read/write, cleared while disabled
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         testPath_r <= `RST_TEST_PATH;
      end else if (!chipEn) begin
         testPath_r <= `RST_TEST_PATH;
      end else if (regWrite && hits(regAddr, `OFS_TEST_PATH)) begin
         testPath_r <= regWrData;
      end
   end

   // Mode control: stop clears the test-entry bits; a write in the same cycle still lands
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         testMode_r <= `RST_TEST_MODE;
      end else if (!chipEn) begin
         testMode_r <= `RST_TEST_MODE;
      end else if (regWrite && hits(regAddr, `OFS_TEST_MODE)) begin
         testMode_r <= regWrData;
      end else if (hostStop) begin
         testMode_r[`BIT_DEC_TEST] <= 1'b0;
         testMode_r[`BIT_IO_TEST1] <= 1'b0;
         testMode_r[`BIT_IO_TEST0] <= 1'b0;
      end
   end

   // ----------------------------------------
   // Pin and analog steering
   // ----------------------------------------
   // Subcarrier path rerouting for direct test access
   assign decoderSubcarrier = testPath_r[`BIT_SUBC_IN] ? keyingPinIn : internalSubcarrier;
   assign modulationPinOe = testPath_r[`BIT_SUBC_OUT];
   assign modulationPinOut = testPath_r[`BIT_SUBC_OUT] & rxSubcarrier;
   // Pin only drives modulation when it is not itself an output
   assign txModulation = (testPath_r[`BIT_DIRECT_MOD] && !testPath_r[`BIT_SUBC_OUT]) ?
                         modulationPinIn : coderModulation;
   assign rxResetReq = testPath_r[`BIT_DIRECT_MOD] & !testPath_r[`BIT_SUBC_OUT] & modulationPinIn;
   assign stageSelect = testPath_r[`BIT_STAGE_SEL];
   assign stage2GainReduce = testPath_r[`BIT_STAGE2_LOW];
   assign stage1GainReduce = testPath_r[`BIT_STAGE1_LOW];
   assign followerTest = testPath_r[`BIT_FOLLOWER_TEST];
   assign rssiMainShown = testPath_r[`BIT_AGC_TEST] ? agcLevel : rssiMainLevel;
   assign rfAmplitudeTest = testMode_r[`BIT_RF_AMP_TEST];
   assign testModeActive = testMode_r[`BIT_DEC_TEST] | testMode_r[`BIT_IO_TEST1] |
                           testMode_r[`BIT_IO_TEST0];
   assign coderFastClock = testMode_r[`BIT_FAST_CLOCK];

   // ----------------------------------------
   // Transmit length registers
   // ----------------------------------------
   // Host write beats the end-of-frame clear so a new length is never lost
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         countHigh_r <= `RST_TX_COUNT;
      end else if (!chipEn) begin
         countHigh_r <= `RST_TX_COUNT;
      end else if (regWrite && hits(regAddr, `OFS_TX_COUNT_HIGH)) begin
         countHigh_r <= regWrData;
      end else if (txEof) begin
         countHigh_r <= `RST_TX_COUNT;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         countLow_r <= `RST_TX_COUNT;
      end else if (!chipEn) begin
         countLow_r <= `RST_TX_COUNT;
      end else if (regWrite && hits(regAddr, `OFS_TX_COUNT_LOW)) begin
         countLow_r <= regWrData;
      end else if (txEof) begin
         countLow_r <= `RST_TX_COUNT;
      end
   end

   assign txByteCount = {countHigh_r, countLow_r[7:4]};
   assign partialByte = countLow_r[`BIT_PARTIAL_FLAG];
   assign partialBits = countLow_r[`BIT_PARTIAL_FLAG] ?
                        countLow_r[`PARTIAL_BITS_MSB:`PARTIAL_BITS_LSB] : 3'h0;

   // ----------------------------------------
   // FIFO pointers and level
   // ----------------------------------------
   // Host fills during transmit set-up; the receiver fills only while receiving
   assign hostWrFifo = regWrite && hits(regAddr, `OFS_FIFO_DATA);
   assign hostRdFifo = regRead && hits(regAddr, `OFS_FIFO_DATA) && (level_r != 5'h00);
   assign rxByteReady = (dir_r == DIR_RX) && (level_r != DEPTH_C) && !hostWrFifo;
   assign pushEn = (hostWrFifo || (rxByteValid && rxByteReady)) && (level_r != DEPTH_C);
   assign pushData = hostWrFifo ? regWrData : rxByte;
   // Coder side drains through the buffer; host reads take priority
   assign bufUsed = {1'b0, bufValid_r[0]} + {1'b0, bufValid_r[1]} + {1'b0, fillPending_r};
   assign fillPop = (dir_r == DIR_TX) && !hostRdFifo && (level_r != 5'h00) && (bufUsed < 2'h2);
   assign popEn = hostRdFifo || fillPop;

   always_comb begin
      levelNxt = level_r;
      if (pushEn && !popEn) begin
         levelNxt = level_r + 5'h01;
      end else if (popEn && !pushEn) begin
         levelNxt = level_r - 5'h01;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wrPtr_r <= 4'h0;
         rdPtr_r <= 4'h0;
         level_r <= 5'h00;
      end else if (!chipEn || fifoClear) begin
         wrPtr_r <= 4'h0;
         rdPtr_r <= 4'h0;
         level_r <= 5'h00;
      end else begin
         if (pushEn) begin
            wrPtr_r <= bump(wrPtr_r);
         end
         if (popEn) begin
            rdPtr_r <= bump(rdPtr_r);
         end
         level_r <= levelNxt;
      end
   end

   // Overflow is sticky until the FIFO is cleared; the event wins over the clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         overflow_r <= 1'b0;
      end else if (!chipEn) begin
         overflow_r <= 1'b0;
      end else if (hostWrFifo && (level_r == DEPTH_C)) begin
         overflow_r <= 1'b1;
      end else if (fifoClear) begin
         overflow_r <= 1'b0;
      end
   end

   fifo_store #(
      .WIDTH(8),
      .DEPTH(DEPTH),
      .AW(AW)
   ) u_store (
      .sys_clk(sys_clk),
      .wrEn(pushEn),
      .wrAddr(wrPtr_r),
      .wrData(pushData),
      .rdEn(popEn),
      .rdAddr(rdPtr_r),
      .rdData(memRdData)
   );

   // ----------------------------------------
   // Two-entry transmit buffer
   // ----------------------------------------
   // Room for the read in flight is reserved, so a coder stall never drops a byte
   assign txDataValid = bufValid_r[bufHead_r];
   assign txData = bufData_r[bufHead_r];
   assign bufTake = txDataValid && txDataReady;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fillPending_r <= 1'b0;
         bufValid_r <= 2'b00;
         bufHead_r <= 1'b0;
         bufData_r[0] <= 8'h00;
         bufData_r[1] <= 8'h00;
      end else if (!chipEn || fifoClear) begin
         fillPending_r <= 1'b0;
         bufValid_r <= 2'b00;
         bufHead_r <= 1'b0;
      end else begin
         fillPending_r <= fillPop;
         if (bufTake) begin
            bufValid_r[bufHead_r] <= 1'b0;
            bufHead_r <= !bufHead_r;
         end
         if (fillPending_r) begin
            // Empty buffer fills the head, else the tail, so bytes leave in FIFO order
            if (bufValid_r[bufHead_r]) begin
               bufData_r[!bufHead_r] <= memRdData;
               bufValid_r[!bufHead_r] <= 1'b1;
            end else begin
               bufData_r[bufHead_r] <= memRdData;
               bufValid_r[bufHead_r] <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // Status view and read-back
   // ----------------------------------------
   always_comb begin
      statusView = 8'h00;
      statusView[`BIT_FIFO_RESERVED] = 1'b0;
      statusView[`BIT_FIFO_HIGH] = (dir_r == DIR_RX) && (level_r >= HIGH_C);
      statusView[`BIT_FIFO_LOW] = (dir_r == DIR_TX) && (level_r <= LOW_C);
      statusView[`BIT_FIFO_OVERFLOW] = overflow_r;
      // Empty reads as zero rather than wrapping
      statusView[`FIFO_COUNT_MSB:0] = (level_r == 5'h00) ? 4'h0 : 4'(level_r - 5'h01);
   end

   assign fifoEvent = statusView[`BIT_FIFO_HIGH] | statusView[`BIT_FIFO_LOW];

   // Register reads answer one cycle later; the status register has no write path
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRd_r <= 8'h00;
         regRdValid_r <= 1'b0;
         hostRdFifo_r <= 1'b0;
      end else begin
         regRdValid_r <= regRead;
         hostRdFifo_r <= hostRdFifo;
         if (!regRead) begin
            regRd_r <= regRd_r;
         end else if (hits(regAddr, `OFS_TEST_PATH)) begin
            regRd_r <= testPath_r;
         end else if (hits(regAddr, `OFS_TEST_MODE)) begin
            regRd_r <= testMode_r;
         end else if (hits(regAddr, `OFS_FIFO_STATUS)) begin
            regRd_r <= statusView;
         end else if (hits(regAddr, `OFS_TX_COUNT_HIGH)) begin
            regRd_r <= countHigh_r;
         end else if (hits(regAddr, `OFS_TX_COUNT_LOW)) begin
            regRd_r <= countLow_r;
         end else begin
            regRd_r <= 8'h00;
         end
      end
   end

   assign regRdData = hostRdFifo_r ? memRdData : regRd_r;
   assign regRdValid = regRdValid_r;
endmodule

`default_nettype wire

//--- test/reader_fifo_regs_assertions.sv
// Checker of the reader FIFO and test register group.
// Assumes it is bound to reader_fifo_regs; one clock, reset high.
`timescale 1ns/1ps
`default_nettype none

module reader_fifo_regs_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic chipEn,
   // Host port
   input wire logic [4:0] regAddr,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regWrData,
   input wire logic [7:0] regRdData,
   input wire logic regRdValid,
   input wire logic hostStop,
   input wire logic txEof,
   // Length and steering
   input wire logic [11:0] txByteCount,
   input wire logic partialByte,
   input wire logic [2:0] partialBits,
   input wire logic keyingPinIn,
   input wire logic rxSubcarrier,
   input wire logic [2:0] agcLevel,
   input wire logic decoderSubcarrier,
   input wire logic modulationPinOut,
   input wire logic modulationPinOe,
   input wire logic [2:0] rssiMainShown,
   input wire logic testModeActive,
   input wire logic coderFastClock
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);

   // A host write that chip enable lets through
   sequence wrAt(logic [4:0] a);
      regWrite && chipEn && regAddr == a;
   endsequence

   a_status_msb_zero: assert property (regRead && regAddr == 5'h1C |=> regRdValid && !regRdData[7])
      else $error("status read bad");
   a_disable_clears: assert property (!chipEn |=> !testModeActive && !coderFastClock)
      else $error("chip disable kept bits");
   a_stop_ends_test: assert property (hostStop && !regWrite |=> !testModeActive)
      else $error("stop left test mode");
   a_test_mode_on: assert property (wrAt(5'h1B) ##0 (|regWrData[3:1]) |=> testModeActive)
      else $error("test mode not entered");
   a_fast_clock_wr: assert property (wrAt(5'h1B) |=> coderFastClock == $past(regWrData[0]))
      else $error("fast clock bit wrong");
   a_keying_route: assert property (wrAt(5'h1A) ##0 regWrData[7] |=> decoderSubcarrier == keyingPinIn)
      else $error("keying pin not routed");
   a_subc_out_pin: assert property (wrAt(5'h1A) ##0 regWrData[6] |=> modulationPinOe && modulationPinOut == rxSubcarrier)
      else $error("subcarrier not on pin");
   a_agc_shown: assert property (wrAt(5'h1A) ##0 regWrData[0] |=> rssiMainShown == agcLevel)
      else $error("gain level not shown");
   a_eof_clears_len: assert property (txEof && chipEn && !regWrite |=> txByteCount == 12'h000 && !partialByte)
      else $error("length kept after frame end");
   a_count_high_wr: assert property (wrAt(5'h1D) |=> txByteCount[11:4] == $past(regWrData))
      else $error("count high bits wrong");
   a_partial_gated: assert property (!partialByte |-> partialBits == 3'h0)
      else $error("partial bits leak");
endmodule

bind reader_fifo_regs reader_fifo_regs_checker chk (.sys_clk, .rst, .chipEn, .regAddr, .regWrite, .regRead,
   .regWrData, .regRdData, .regRdValid, .hostStop, .txEof, .txByteCount, .partialByte, .partialBits,
   .keyingPinIn, .rxSubcarrier, .agcLevel, .decoderSubcarrier, .modulationPinOut, .modulationPinOe,
   .rssiMainShown, .testModeActive, .coderFastClock);
`default_nettype wire

//--- test/coder_link_model.sv
// Model of the protocol engine side: byte source and byte sink.
// Assumes the block's ready on receive and valid on transmit.
`timescale 1ns/1ps
`default_nettype none

module coder_link_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // Controls from the bench
   input wire logic [3:0] rxCount,
   input wire logic txStall,
   // Receive byte source
   output logic rxByteValid,
   output logic [7:0] rxByte,
   input wire logic rxByteReady,
   // Transmit byte sink
   input wire logic txDataValid,
   input wire logic [7:0] txData,
   output logic txDataReady
);
   logic [3:0] sentN;
   logic [3:0] nextN;
   logic [3:0] gotN;
   logic [7:0] got [0:15];

   // Count after this edge's handshake
   assign nextN = sentN + {3'h0, rxByteValid & rxByteReady};
   assign txDataReady = !txStall;

   // Offer held until taken; idle data toggles so nothing stale looks valid
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sentN <= 4'h0;
         rxByteValid <= 1'b0;
         rxByte <= 8'h00;
      end else begin
         sentN <= nextN;
         rxByteValid <= nextN < rxCount;
         rxByte <= (nextN < rxCount) ? 8'h30 + {4'h0, nextN} : ~rxByte;
      end
   end

   // Collect every transmit byte in arrival order
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gotN <= 4'h0;
      end else if (txDataValid && txDataReady) begin
         got[gotN] <= txData;
         gotN <= gotN + 4'h1;
      end
   end
endmodule
`default_nettype wire

//--- test/reader_fifo_regs_tb.sv
// Self-checking bench of the reader FIFO and test register group.
// Assumes the design and coder_link_model sources are compiled first.
`timescale 1ns/1ps
`default_nettype none

module reader_fifo_regs_tb import reader_regs_pkg::*; ;
   logic sys_clk, rst, chipEn, regWrite, regRead, hostStop, txActive, rxActive, txEof, fifoClear;
   logic rxByteValid, rxByteReady, txDataValid, txDataReady, keyingPinIn, modulationPinIn;
   logic internalSubcarrier, rxSubcarrier, coderModulation, regRdValid, partialByte, txStall;
   logic modulationPinOut, modulationPinOe, decoderSubcarrier, txModulation, rxResetReq, stageSelect;
   logic stage1GainReduce, stage2GainReduce, followerTest, rfAmplitudeTest, testModeActive;
   logic coderFastClock, fifoEvent;
   logic [4:0] regAddr;
   logic [7:0] regWrData, regRdData, rxByte, txData;
   logic [11:0] txByteCount;
   logic [2:0] partialBits, rssiMainLevel, agcLevel, rssiMainShown;
   logic [3:0] rxCount;
   int mismatches = 0;
   int checked = 0;

   reader_fifo_regs uut (.sys_clk, .rst, .chipEn, .regAddr, .regWrite, .regRead, .regWrData, .regRdData,
      .regRdValid, .hostStop, .txActive, .rxActive, .txEof, .fifoClear, .rxByteValid, .rxByte, .rxByteReady,
      .txDataValid, .txData, .txDataReady, .txByteCount, .partialByte, .partialBits, .keyingPinIn,
      .modulationPinIn, .modulationPinOut, .modulationPinOe, .internalSubcarrier, .rxSubcarrier,
      .coderModulation, .rssiMainLevel, .agcLevel, .decoderSubcarrier, .txModulation, .rxResetReq,
      .stageSelect, .stage1GainReduce, .stage2GainReduce, .followerTest, .rfAmplitudeTest, .rssiMainShown,
      .testModeActive, .coderFastClock, .fifoEvent);
   coder_link_model link (.sys_clk, .rst, .rxCount, .txStall, .rxByteValid, .rxByte, .rxByteReady,
      .txDataValid, .txData, .txDataReady);

   // ----------------------------------------
   // Clock, watchdog and access tasks
   // ----------------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // Whole run takes under two thousand ns; this only cuts a hang
   initial begin
      #50000;
      mismatches++;
      tally_and_finish();
   end

   task automatic tally_and_finish;
      $display("checked %0d, mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk) #1;
      regWrite = 1'b1;
      regAddr = a;
      regWrData = d;
      @(posedge sys_clk) #1;
      regWrite = 1'b0;
   endtask

   // Read answers one cycle after the strobe edge
   task automatic rdc(input logic [4:0] a, input logic [7:0] e);
      @(posedge sys_clk) #1;
      regRead = 1'b1;
      regAddr = a;
      @(posedge sys_clk) #1;
      regRead = 1'b0;
      chk({regRdValid, regRdData}, {1'b1, e});
   endtask

   task automatic pls(ref logic s, input logic v);
      @(posedge sys_clk) #1;
      s = v;
      @(posedge sys_clk) #1;
      s = !v;
   endtask

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      {rst, chipEn, keyingPinIn, modulationPinIn, rxSubcarrier} = 5'h1F;
      {regWrite, regRead, hostStop, txActive, rxActive, txEof, fifoClear, txStall} = 8'h00;
      {internalSubcarrier, coderModulation, regAddr, regWrData, rxCount} = '0;
      rssiMainLevel = 3'h2;
      agcLevel = 3'h5;
      repeat (10) @(posedge sys_clk);
      #1 rst = 1'b0;
      for (int a = 26; a < 31; a++) rdc(a[4:0], 8'h00);
      rdc(5'h00, 8'h00);
      wr(5'h1A, 8'h80);
      chk(decoderSubcarrier, 1'b1);
      keyingPinIn = 1'b0;
      #1 chk(decoderSubcarrier, 1'b0);
      wr(5'h1A, 8'h40);
      chk({modulationPinOe, modulationPinOut}, 2'h3);
      wr(5'h1A, 8'h20);
      chk({txModulation, rxResetReq}, 2'h3);
      wr(5'h1A, 8'h1D);
      chk({stageSelect, stage2GainReduce, stage1GainReduce, followerTest, rssiMainShown}, 7'h75);
      rdc(5'h1A, 8'h1D);
      wr(5'h1A, 8'h00);
      chk({decoderSubcarrier, txModulation, rssiMainShown}, 5'h02);
      wr(5'h1B, 8'h8F);
      chk({testModeActive, coderFastClock, rfAmplitudeTest}, 3'h7);
      pls(hostStop, 1'b1);
      rdc(5'h1B, 8'h81);
      wr(5'h1B, 8'h04);
      chk(testModeActive, 1'b1);
      wr(5'h1A, 8'hFF);
      pls(chipEn, 1'b0);
      rdc(5'h1A, 8'h00);
      rdc(5'h1B, 8'h00);
      wr(5'h1D, 8'hA5);
      wr(5'h1E, 8'h3B);
      chk({txByteCount, partialByte, partialBits}, 16'hA53D);
      wr(5'h1E, 8'h3A);
      chk({partialByte, partialBits}, 4'h0);
      pls(txEof, 1'b1);
      rdc(5'h1D, 8'h00);
      rdc(5'h1E, 8'h00);
      wr(5'h1C, 8'hFF);
      rdc(5'h1C, 8'h00);
      for (int i = 0; i < 12; i++) wr(5'h1F, 8'h50 + 8'(i));
      rdc(5'h1C, 8'h0B);
      wr(5'h1F, 8'hEE);
      rdc(5'h1C, 8'h1B);
      rdc(5'h1F, 8'h50);
      pls(fifoClear, 1'b1);
      rdc(5'h1C, 8'h00);
      // Receive until nine bytes sit in the FIFO
      rxActive = 1'b1;
      rxCount = 4'h9;
      for (int i = 0; i < 40 && link.sentN != 4'h9; i++) @(posedge sys_clk);
      rdc(5'h1C, 8'h48);
      chk(fifoEvent, 1'b1);
      rdc(5'h1F, 8'h30);
      rdc(5'h1C, 8'h07);
      chk(fifoEvent, 1'b0);
      for (int i = 1; i < 9; i++) rdc(5'h1F, 8'h30 + 8'(i));
      rxActive = 1'b0;
      // Transmit five bytes with the coder stalled first
      txStall = 1'b1;
      for (int i = 0; i < 5; i++) wr(5'h1F, 8'h60 + 8'(i));
      txActive = 1'b1;
      for (int i = 0; i < 20 && txDataValid !== 1'b1; i++) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      rdc(5'h1C, 8'h22);
      chk(fifoEvent, 1'b1);
      txStall = 1'b0;
      for (int i = 0; i < 40 && link.gotN != 4'h5; i++) @(posedge sys_clk);
      for (int i = 0; i < 5; i++) chk(link.got[i], 8'h60 + 8'(i));
      rdc(5'h1C, 8'h20);
      txActive = 1'b0;
      tally_and_finish();
   end
endmodule
`default_nettype wire
